/* File: rtl/sfp_sequencer.sv */
// Serial flash program command decoder, page buffers and self-timed sequencer.
//
// Function
// - 88H/89H: program page without erase
// - Four reserved, 11-bit page, nine filler bits
// - Start only on select rise after full frame
// - Busy on pin and status bit meanwhile
// - Other buffer stays writable while busy
// - 82H/85H: buffer write plus page program
// - Address: 11-bit page, 9-bit byte position
// - Data bytes stored incrementing, wrapping at end
// - Select rise erases then programs the page
// - 58H/59H: auto page rewrite, page frame
// - Rewrite copies page, erases, reprograms it
// - 83H/86H: program with built-in erase
// - Two buffers of 264 bytes each
`timescale 1ns/10ps
`default_nettype none
`include "sfp_defines.svh"
module sfp_sequencer (
  // Clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // Serial pins from the host
  input wire logic cs_n_in,
  input wire logic sck_in,
  input wire logic si_in,
  // Ready indication
  output logic ready_pin_out,
  output logic stat_ready_out,
  // Flash array port
  output sfp_pkg::sfp_arr_cmd_t arr_cmd_out,
  input wire logic [7:0] arr_rdata_in
);
  import sfp_pkg::*;

  function automatic logic op_buf2(input logic [7:0] op);
    op_buf2 = (op == `SFP_OP_PWO_B2) || (op == `SFP_OP_MMP_B2) || (op == `SFP_OP_PBE_B2) ||
              (op == `SFP_OP_APR_B2) || (op == `SFP_OP_BWR_B2);
  endfunction : op_buf2

  function automatic logic op_fills(input logic [7:0] op);
    op_fills = (op == `SFP_OP_MMP_B1) || (op == `SFP_OP_MMP_B2) ||
               (op == `SFP_OP_BWR_B1) || (op == `SFP_OP_BWR_B2);
  endfunction : op_fills

  function automatic logic op_job(input logic [7:0] op);
    op_job = (op == `SFP_OP_PWO_B1) || (op == `SFP_OP_PWO_B2) || (op == `SFP_OP_MMP_B1) ||
             (op == `SFP_OP_MMP_B2) || (op == `SFP_OP_PBE_B1) || (op == `SFP_OP_PBE_B2) ||
             (op == `SFP_OP_APR_B1) || (op == `SFP_OP_APR_B2);
  endfunction : op_job

  function automatic logic [8:0] col_inc(input logic [8:0] col);
    col_inc = (col == `SFP_BUF_LAST) ? 9'h000 : col + 9'h001;
  endfunction : col_inc

  // Pin synchronisers; the third stage only serves edge detection.
  logic [2:0] cs_sync, sck_sync;
  logic [1:0] si_sync;
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cs_sync <= 3'h7;
      sck_sync <= 3'h0;
      si_sync <= 2'h0;
    end else begin
      cs_sync <= {cs_sync[1:0], cs_n_in};
      sck_sync <= {sck_sync[1:0], sck_in};
      si_sync <= {si_sync[0], si_in};
    end
  end
  logic sel, sck_rise, cs_rise;
  assign sel = !cs_sync[1];
  assign sck_rise = sel && sck_sync[1] && !sck_sync[2];
  assign cs_rise = cs_sync[1] && !cs_sync[2];

  // Frame shifter.
  logic [31:0] frame;
  logic [5:0] nbits;
  logic [2:0] nbit8;
  logic [7:0] dbyte;
  logic [8:0] wcol;
  logic frame_done;
  assign frame_done = (nbits == `SFP_FRAME_BITS);
  logic [7:0] opc;
  assign opc = frame[`SFP_OPC_MSB:`SFP_OPC_LSB];

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      frame <= 32'h0;
      nbits <= 6'h0;
      nbit8 <= 3'h0;
      dbyte <= 8'h0;
    end else if (!sel) begin
      nbits <= 6'h0;
      nbit8 <= 3'h0;
    end else if (sck_rise) begin
      if (!frame_done) begin
        frame <= {frame[30:0], si_sync[1]};
        nbits <= nbits + 6'h01;
      end else begin
        dbyte <= {dbyte[6:0], si_sync[1]};
        nbit8 <= nbit8 + 3'h1;
      end
    end
  end

  // Serial byte write into a buffer.
  logic sw_en, sw_buf;
  logic [7:0] sw_data;
  logic byte_end;
  assign byte_end = sck_rise && frame_done && (nbit8 == `SFP_BYTE_LAST);

  sfp_state_t state;
  logic job_buf;
  logic busy;
  assign busy = (state != SFP_IDLE);

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sw_en <= 1'b0;
      sw_buf <= 1'b0;
      sw_data <= 8'h0;
      wcol <= 9'h0;
    end else begin
      // A write into the buffer that the array is using is dropped.
      sw_en <= byte_end && op_fills(opc) && !(busy && (op_buf2(opc) == job_buf));
      sw_buf <= op_buf2(opc);
      sw_data <= {dbyte[6:0], si_sync[1]};
      if (sck_rise && (nbits == `SFP_FRAME_BITS - 6'h01)) begin
        wcol <= {frame[7:0], si_sync[1]};
      end else if (sw_en) begin
        wcol <= col_inc(wcol);
      end
    end
  end

  // Page buffers.
  logic [7:0] buf_mem [2][`SFP_BUF_BYTES];
  logic cp_en;
  logic [8:0] cp_col;
  logic cp_pend;
  logic [8:0] cp_pcol;
  logic [8:0] sw_col;
  assign sw_col = wcol;
  for (genvar b = 0; b < 2; b++) begin : g_buf
    always_ff @(posedge clk_in) begin
      if (sw_en && (sw_buf == 1'(b))) begin
        buf_mem[b][sw_col] <= sw_data;
      end else if (cp_en && (job_buf == 1'(b))) begin
        buf_mem[b][cp_col] <= arr_rdata_in;
      end
    end
  end

  // Job sequencer.
  logic [10:0] job_page;
  logic job_copy, job_erase;
  logic [8:0] idx;
  logic [15:0] timer;
  logic start;
  assign start = cs_rise && frame_done && op_job(opc) && !busy;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state <= SFP_IDLE;
      job_buf <= 1'b0;
      job_page <= 11'h0;
      job_copy <= 1'b0;
      job_erase <= 1'b0;
      idx <= 9'h0;
      timer <= 16'h0;
      cp_en <= 1'b0;
      cp_col <= 9'h0;
      cp_pend <= 1'b0;
      cp_pcol <= 9'h0;
      arr_cmd_out <= '0;
    end else begin
      arr_cmd_out.valid <= 1'b0;
      cp_pend <= 1'b0;
      // Read data stands one cycle after the strobe, so the capture trails the strobe by one stage.
      cp_en <= cp_pend;
      cp_col <= cp_pcol;
      case (state)
        SFP_IDLE: begin
          if (start) begin
            job_buf <= op_buf2(opc);
            job_page <= frame[`SFP_PAGE_MSB:`SFP_PAGE_LSB];
            job_copy <= (opc == `SFP_OP_APR_B1) || (opc == `SFP_OP_APR_B2);
            job_erase <= !((opc == `SFP_OP_PWO_B1) || (opc == `SFP_OP_PWO_B2));
            idx <= 9'h0;
            if ((opc == `SFP_OP_APR_B1) || (opc == `SFP_OP_APR_B2)) begin
              state <= SFP_COPY;
            end else if ((opc == `SFP_OP_PWO_B1) || (opc == `SFP_OP_PWO_B2)) begin
              state <= SFP_PROG;
            end else begin
              state <= SFP_ERASE;
            end
          end
        end
        SFP_COPY: begin
          arr_cmd_out <= '{valid: 1'b1, op: SFP_ARR_READ, page: job_page, col: idx, data: 8'h0};
          cp_pend <= 1'b1;
          cp_pcol <= idx;
          idx <= col_inc(idx);
          if (idx == `SFP_BUF_LAST) begin
            state <= SFP_ERASE;
          end
        end
        SFP_ERASE: begin
          if (timer == 16'h0) begin
            arr_cmd_out <= '{valid: 1'b1, op: SFP_ARR_ERASE, page: job_page, col: 9'h0, data: 8'h0};
            timer <= 16'(`SFP_ERASE_CYC);
          end else if (timer == 16'h1) begin
            timer <= 16'h0;
            idx <= 9'h0;
            state <= SFP_PROG;
          end else begin
            timer <= timer - 16'h1;
          end
        end
        SFP_PROG: begin
          arr_cmd_out <= '{valid: 1'b1, op: SFP_ARR_WRITE, page: job_page, col: idx,
                           data: buf_mem[job_buf][idx]};
          idx <= col_inc(idx);
          if (idx == `SFP_BUF_LAST) begin
            timer <= 16'(`SFP_PROG_CYC);
            state <= SFP_WAIT;
          end
        end
        SFP_WAIT: begin
          timer <= timer - 16'h1;
          if (timer == 16'h1) begin
            timer <= 16'h0;
            state <= SFP_IDLE;
          end
        end
        default: state <= SFP_IDLE;
      endcase
    end
  end

  // Ready drops on the same edge that leaves idle, so a host still sees ready for three clocks after select rises.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ready_pin_out <= 1'b1;
      stat_ready_out <= 1'b1;
    end else begin
      ready_pin_out <= !(busy || start);
      stat_ready_out <= !(busy || start);
    end
  end

  a_start_busy: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    start |=> ##1 !ready_pin_out) else $error("ready not dropped after start");
  a_no_start_early: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (state == SFP_IDLE && !frame_done) |=> state == SFP_IDLE) else $error("job without full frame");
  a_pin_status: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    ready_pin_out == stat_ready_out) else $error("pin and status differ");
  a_busy_ready: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (state == SFP_WAIT && timer == 16'h1) |=> ##1 ready_pin_out) else $error("ready not restored");
  a_other_buf: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (sw_en && busy && $past(busy)) |-> sw_buf != job_buf) else $error("busy buffer written");
  a_col_wrap: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (sw_en && wcol == `SFP_BUF_LAST && !(sck_rise && nbits == `SFP_FRAME_BITS - 6'h01)) |=> wcol == 9'h0)
    else $error("column did not wrap");
  a_erase_first: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (state == SFP_IDLE && start && op_fills(opc)) |=> state == SFP_ERASE) else $error("no erase");
  a_pwo_no_erase: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (start && (opc == `SFP_OP_PWO_B1)) |=> state == SFP_PROG && !job_buf) else $error("bad program");
  a_rewrite_copy: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (start && (opc == `SFP_OP_APR_B2)) |=> state == SFP_COPY ##264 state == SFP_ERASE)
    else $error("rewrite did not copy");
  c_program: cover property (@(posedge clk_in) disable iff (!arst_n_in) start && !job_copy ##1 state == SFP_PROG);
  c_rewrite: cover property (@(posedge clk_in) disable iff (!arst_n_in) state == SFP_COPY && job_erase);
  c_pingpong: cover property (@(posedge clk_in) disable iff (!arst_n_in) sw_en && busy);
endmodule : sfp_sequencer
`default_nettype wire

/* File: rtl/sfp_defines.svh */
// Constants for the serial flash program sequencer.
`ifndef SFP_DEFINES_SVH
`define SFP_DEFINES_SVH
`define SFP_OP_PWO_B1 8'h88
`define SFP_OP_PWO_B2 8'h89
`define SFP_OP_MMP_B1 8'h82
`define SFP_OP_MMP_B2 8'h85
`define SFP_OP_PBE_B1 8'h83
`define SFP_OP_PBE_B2 8'h86
`define SFP_OP_APR_B1 8'h58
`define SFP_OP_APR_B2 8'h59
`define SFP_OP_BWR_B1 8'h84
`define SFP_OP_BWR_B2 8'h87
`define SFP_FRAME_BITS 6'h20
`define SFP_BYTE_LAST 3'h7
`define SFP_OPC_MSB 31
`define SFP_OPC_LSB 24
`define SFP_PAGE_MSB 19
`define SFP_PAGE_LSB 9
`define SFP_COL_MSB 8
`define SFP_BUF_BYTES 264
`define SFP_BUF_LAST 9'h107
`define SFP_CLK_NS 100
`define SFP_ERASE_NS 20000
`define SFP_PROG_NS 14000
`define SFP_ERASE_CYC ((`SFP_ERASE_NS + `SFP_CLK_NS - 1) / `SFP_CLK_NS)
`define SFP_PROG_CYC ((`SFP_PROG_NS + `SFP_CLK_NS - 1) / `SFP_CLK_NS)
`endif

/* File: rtl/sfp_pkg.sv */
// Types shared by the serial flash program sequencer.
package sfp_pkg;
  typedef enum logic [1:0] {SFP_ARR_NOP, SFP_ARR_READ, SFP_ARR_ERASE, SFP_ARR_WRITE} sfp_arr_op_t;
  typedef enum logic [2:0] {SFP_IDLE, SFP_COPY, SFP_ERASE, SFP_PROG, SFP_WAIT} sfp_state_t;
  typedef struct packed {
    logic valid;
    sfp_arr_op_t op;
    logic [10:0] page;
    logic [8:0] col;
    logic [7:0] data;
  } sfp_arr_cmd_t;
endpackage : sfp_pkg

/* File: test/sfp_host.sv */
// Behavioural host that drives the serial pins of the sequencer.
`timescale 1ns/10ps
`default_nettype none
module sfp_host (
  // Clock
  input wire logic clk_in,
  // Serial pins
  output logic cs_n_out,
  output logic sck_out,
  output logic si_out
);
  initial begin
    cs_n_out = 1'h1;
    sck_out = 1'h0;
    si_out = 1'h0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask : tick
  task automatic sel(input logic lvl);
    tick(1);
    cs_n_out <= lvl;
    // A released data line flips so that a stale bit is never taken for a fresh one.
    if (lvl) si_out <= ~si_out;
    tick(3);
  endtask : sel
  // Each bit is held three clocks before and four after its clock rise, most significant first.
  task automatic bits(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      tick(1);
      si_out <= v[i];
      sck_out <= 1'h0;
      tick(3);
      sck_out <= 1'h1;
      tick(3);
    end
  endtask : bits
endmodule : sfp_host
`default_nettype wire

/* File: test/tb_sfp_sequencer.sv */
// Self-checking bench for the serial flash program sequencer.
`timescale 1ns/10ps
`default_nettype none
module tb_sfp_sequencer;
  import sfp_pkg::*;
  `define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; \
    $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
  typedef struct packed {logic [7:0] op; logic [10:0] pg; logic cp; logic er;} sfp_row_t;
  logic clk_in = 1'h0;
  logic arst_n_in;
  logic cs_n, sck, si, ready_pin, stat_ready, order_bad;
  logic [7:0] arr_rdata;
  logic [9:0] n_rd, n_er, n_wr;
  logic [10:0] wr_page, er_page;
  logic [7:0] wdat [0:263];
  sfp_arr_cmd_t arr_cmd;
  int miscompares = 0;
  int checks = 0;
  // Pages 001 and 7ff are erased by the first two rows before they are programmed without erase.
  sfp_row_t rows [8] = '{'{8'h83, 11'h001, 1'h0, 1'h1}, '{8'h86, 11'h7ff, 1'h0, 1'h1},
    '{8'h88, 11'h001, 1'h0, 1'h0}, '{8'h89, 11'h7ff, 1'h0, 1'h0}, '{8'h58, 11'h555, 1'h1, 1'h1},
    '{8'h59, 11'h0ff, 1'h1, 1'h1}, '{8'h82, 11'h123, 1'h0, 1'h1}, '{8'h85, 11'h3c0, 1'h0, 1'h1}};
  always #50 clk_in = ~clk_in;
  sfp_host i_host (.clk_in(clk_in), .cs_n_out(cs_n), .sck_out(sck), .si_out(si));
  sfp_sequencer i_dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .cs_n_in(cs_n), .sck_in(sck), .si_in(si),
    .ready_pin_out(ready_pin), .stat_ready_out(stat_ready), .arr_cmd_out(arr_cmd), .arr_rdata_in(arr_rdata));
  // The array answers a read with a byte derived from its position, one clock later.
  always @(posedge clk_in) begin
    arr_rdata <= arr_cmd.col[7:0] ^ 8'h5a;
    if (arr_cmd.valid === 1'h1) begin
      if (arr_cmd.op == SFP_ARR_READ && (n_er != 0 || n_wr != 0)) order_bad = 1'h1;
      if (arr_cmd.op == SFP_ARR_ERASE && n_wr != 0) order_bad = 1'h1;
      if (arr_cmd.op == SFP_ARR_READ) n_rd++;
      if (arr_cmd.op == SFP_ARR_ERASE) begin
        n_er++;
        er_page = arr_cmd.page;
      end
      if (arr_cmd.op == SFP_ARR_WRITE) begin
        n_wr++;
        wr_page = arr_cmd.page;
        wdat[arr_cmd.col] = arr_cmd.data;
      end
    end
  end
  task automatic wait_rdy(input logic lvl, input int n);
    for (int i = 0; i < n && ready_pin !== lvl; i++) begin
      @(posedge clk_in);
      #1;
    end
    if (ready_pin !== lvl) begin
      miscompares++;
      results();
    end
  endtask : wait_rdy
  // Reserved bits go out as zero and the filler or start position follows the page.
  task automatic start_job(input logic [7:0] op, input logic [10:0] pg, input logic [8:0] col, input int nb,
      input logic [23:0] dat);
    n_rd = 0;
    n_er = 0;
    n_wr = 0;
    order_bad = 1'h0;
    i_host.sel(1'h0);
    i_host.bits({op, 4'h0, pg, col}, 32);
    i_host.bits({8'h00, dat}, nb * 8);
    #1;
    `CHK(ready_pin, 1'h1)
    i_host.sel(1'h1);
    wait_rdy(1'h0, 10);
    `CHK(stat_ready, 1'h0)
  endtask : start_job
  // The host waits for ready before the next job.
  task automatic end_job(input logic cp, input logic er, input logic [10:0] pg);
    wait_rdy(1'h1, 2000);
    `CHK(stat_ready, 1'h1)
    `CHK(n_rd, cp ? 10'h108 : 10'h000)
    `CHK(n_er, {9'h000, er})
    `CHK(n_wr, 10'h108)
    `CHK(wr_page, pg)
    if (er) `CHK(er_page, pg)
    `CHK(order_bad, 1'h0)
  endtask : end_job
  task automatic results();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results
  initial begin
    arst_n_in <= 1'h0;
    repeat (5) @(posedge clk_in);
    #1;
    `CHK(ready_pin, 1'h1)
    `CHK(arr_cmd, '0)
    repeat (5) @(posedge clk_in);
    arst_n_in <= 1'h1;
    // The run reprograms far fewer than 10,000 pages, so no refresh pass is owed.
    for (int r = 0; r < 8; r++) begin
      start_job(rows[r].op, rows[r].pg, 9'h000, 0, 24'h0);
      end_job(rows[r].cp, rows[r].er, rows[r].pg);
      if (rows[r].cp) `CHK(wdat[5], 8'h5f)
    end
    // Bytes start near the end of the buffer and wrap to position zero.
    start_job(8'h82, 11'h0a5, 9'h106, 3, 24'ha1a2a3);
    end_job(1'h0, 1'h1, 11'h0a5);
    `CHK({wdat[262], wdat[263], wdat[0]}, 24'ha1a2a3)
    // The second buffer is filled while the first one programs.
    start_job(8'h83, 11'h007, 9'h000, 0, 24'h0);
    i_host.sel(1'h0);
    i_host.bits({8'h87, 15'h0000, 9'h004}, 32);
    i_host.bits({24'h0, 8'hc3}, 8);
    i_host.sel(1'h1);
    end_job(1'h0, 1'h1, 11'h007);
    start_job(8'h86, 11'h008, 9'h000, 0, 24'h0);
    end_job(1'h0, 1'h1, 11'h008);
    `CHK(wdat[4], 8'hc3)
    // A frame cut short starts nothing.
    n_wr = 0;
    i_host.sel(1'h0);
    i_host.bits({12'h0, 8'h88, 12'h001}, 20);
    i_host.sel(1'h1);
    i_host.tick(20);
    #1;
    `CHK(ready_pin, 1'h1)
    `CHK(n_wr, 10'h000)
    results();
  end
endmodule : tb_sfp_sequencer
`default_nettype wire
